/* File: tx_cwb_pkg.sv */
// Constants for the transmit completion write-back and launch-time block
package tx_cwb_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_Q = 4;
  localparam int PTR_W = 16;
  localparam int ADDR_W = 16;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] LOW_BASE = 16'hE038;
  localparam logic [ADDR_W-1:0] HIGH_BASE = 16'hE03C;
  localparam logic [ADDR_W-1:0] Q_STRIDE = 16'h0040;
  localparam logic [ADDR_W-1:0] ALIAS_LOW_BASE = 16'h3838;
  localparam logic [ADDR_W-1:0] ALIAS_HIGH_BASE = 16'h383C;
  localparam logic [ADDR_W-1:0] ALIAS_STRIDE = 16'h0100;
  localparam logic [ADDR_W-1:0] CTRL_BASE = 16'hE020;
  localparam logic [ADDR_W-1:0] HEAD_BASE = 16'hE024;
  localparam logic [ADDR_W-1:0] TAIL_BASE = 16'hE030;
  localparam logic [ADDR_W-1:0] BIAS_ADDR = 16'h3578;
  // ==========================================================
  // Field positions
  localparam int HWB_EN_BIT = 0;
  localparam int WB_EXP_BIT = 1;
  localparam int LOW_ADDR_LSB = 2;
  localparam int QWORD_LSB = 3;
  localparam int ENABLE_BIT = 25;
  localparam int FLUSH_BIT = 26;
  localparam int BIAS_LSB = 5;
  localparam int BIAS_MSB = 29;
  localparam int BIAS_FIXED_BIT = 31;
  localparam int BIAS_W = BIAS_MSB - BIAS_LSB + 1;
  // ==========================================================
  // Reset values and units
  localparam logic [31:0] LOW_RESET = 32'h0000_0000;
  localparam logic [31:0] HIGH_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [BIAS_W-1:0] BIAS_RESET = 25'h000_0000;
  localparam logic BIAS_FIXED_RESET = 1'b1;
  localparam int BIAS_UNIT_NS = 32;
  localparam int BIAS_SHIFT = $clog2(BIAS_UNIT_NS);
  localparam logic [31:0] ERR_DATA = 32'h0000_0000;
endpackage

/* File: completion_queue.sv */
// One transmit queue: completion address, control, head and tail, write-back requests
`timescale 1ns/1ps
module completion_queue
  import tx_cwb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire logic i_wr_ctrl,
  input wire logic i_wr_tail,
  input wire logic [31:0] i_wdata,
  input wire logic i_desc_done,
  input wire logic i_throttle_expiry,
  input wire logic i_thresh_req,
  input wire logic i_wb_grant,
  output logic [31:0] o_low,
  output logic [31:0] o_high,
  output logic [31:0] o_ctrl,
  output logic [PTR_W-1:0] o_head,
  output logic [PTR_W-1:0] o_tail,
  output logic o_wb_pending,
  output logic o_flush_pulse,
  output logic o_desc_wb_allow
);
  logic [31:0] low_q;
  logic [31:0] high_q;
  logic [31:0] ctrl_q;
  logic [PTR_W-1:0] head_q;
  logic [PTR_W-1:0] tail_q;
  logic pend_q;
  logic flush_q;
  logic allow_q;

  // ==========================================================
  // Decoded control
  wire hwb_en = low_q[HWB_EN_BIT];
  wire enabled = ctrl_q[ENABLE_BIT];
  wire enable_rise = i_wr_ctrl && i_wdata[ENABLE_BIT] && !enabled;
  wire flush_rise = i_wr_ctrl && i_wdata[FLUSH_BIT] && !ctrl_q[FLUSH_BIT];
  wire head_adv = enabled && i_desc_done && (head_q != tail_q);
  wire wb_event = hwb_en && ((i_throttle_expiry && low_q[WB_EXP_BIT]) || i_thresh_req); // [RULE3]
  wire [PTR_W-1:0] head_d = enable_rise ? '0 : head_q + PTR_W'(1); // [RULE16]

  // ==========================================================
  // Registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      low_q <= LOW_RESET; // [RULE1]
      high_q <= HIGH_RESET; // [RULE5]
      ctrl_q <= CTRL_RESET;
      head_q <= '0;
      tail_q <= '0;
    end
    else
    begin
      if (i_wr_low)
        low_q <= i_wdata; // [RULE1] [RULE4]
      if (i_wr_high)
        high_q <= i_wdata; // [RULE5]
      if (i_wr_ctrl)
        ctrl_q <= i_wdata;
      if (enable_rise || head_adv)
        head_q <= head_d; // [RULE16]
      if (enable_rise)
        tail_q <= '0; // [RULE16]
      else if (i_wr_tail)
        tail_q <= i_wdata[PTR_W-1:0];
    end
  end

  // New event wins over a grant in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      pend_q <= 1'b0;
      flush_q <= 1'b0;
      allow_q <= 1'b1;
    end
    else
    begin
      pend_q <= wb_event || (pend_q && !i_wb_grant && hwb_en);
      flush_q <= flush_rise && !hwb_en; // [RULE2] [RULE14]
      allow_q <= !(i_wr_low ? i_wdata[HWB_EN_BIT] : hwb_en); // [RULE2]
    end
  end

  assign o_low = low_q;
  assign o_high = high_q;
  assign o_ctrl = ctrl_q;
  assign o_head = head_q;
  assign o_tail = tail_q;
  assign o_wb_pending = pend_q;
  assign o_flush_pulse = flush_q;
  assign o_desc_wb_allow = allow_q;
endmodule

/* File: tx_completion_writeback_launch.sv */
// Top: APB register file, head write-back engine and launch-time adder
`timescale 1ns/1ps
// How it works
// (RULE1) Low bit 0 enables head write-back
// (RULE2) Head write-back on: no flush, no descriptor write-back
// (RULE3) Bit 1 writes head on throttle expiry
// (RULE4) Low bits 31:2 give address, quadword aligned
// (RULE5) High register gives upper 32 address bits
// (RULE6) Software writes addresses only while queue disabled
// (RULE7) Low 0xE038, high 0xE03C, stride 0x40
// (RULE8) Low also answers at legacy aliases
// (RULE9) High also answers at legacy aliases
// (RULE10) Bias field bits 29:5, 32 ns units
// (RULE11) Launch time is bias plus relative time
// (RULE12) Software keeps launch time below one second
// (RULE13) Bias bit 31 resets one; 30, 4:0 zero
// (RULE14) Software flush forces descriptor write-back flush
// (RULE15) Software sets expiry bit when threshold used
// (RULE16) Queue enable initialises head and tail
// (RULE17) Head written to concatenated completion address
module tx_completion_writeback_launch
  import tx_cwb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_Q-1:0] i_desc_done,
  input wire logic [NUM_Q-1:0] i_throttle_expiry,
  input wire logic [NUM_Q-1:0] i_thresh_req,
  output logic o_mem_wr_valid,
  output logic [63:0] o_mem_wr_addr,
  output logic [31:0] o_mem_wr_data,
  output logic [1:0] o_mem_wr_queue,
  input wire logic i_mem_wr_ready,
  output logic [NUM_Q-1:0] o_desc_flush,
  output logic [NUM_Q-1:0] o_desc_wb_allow,
  input wire logic i_launch_req,
  input wire logic [31:0] i_rel_launch_time,
  output logic o_launch_valid,
  output logic [31:0] o_launch_time
);
  typedef enum logic [0:0] {WB_IDLE, WB_BUSY} wb_state_e;

  // ==========================================================
  // APB handshake
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  wire apb_access = i_psel && i_penable;
  wire apb_commit = apb_access && pready_q;
  wire apb_wr = apb_commit && i_pwrite;
  wire word_aligned = (i_paddr[1:0] == 2'b00);

  // ==========================================================
  // Per-queue decode
  logic [NUM_Q-1:0] hit_low;
  logic [NUM_Q-1:0] hit_high;
  logic [NUM_Q-1:0] hit_ctrl;
  logic [NUM_Q-1:0] hit_head;
  logic [NUM_Q-1:0] hit_tail;
  logic [31:0] q_low [NUM_Q];
  logic [31:0] q_high [NUM_Q];
  logic [31:0] q_ctrl [NUM_Q];
  logic [PTR_W-1:0] q_head [NUM_Q];
  logic [PTR_W-1:0] q_tail [NUM_Q];
  logic [NUM_Q-1:0] q_pend;
  logic [NUM_Q-1:0] q_grant;

  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++)
    begin : g_queue
      localparam logic [ADDR_W-1:0] QOFF = ADDR_W'(g) * Q_STRIDE;
      localparam logic [ADDR_W-1:0] AOFF = ADDR_W'(g) * ALIAS_STRIDE;

      assign hit_low[g] = (i_paddr == LOW_BASE + QOFF) || // [RULE7]
                          (i_paddr == ALIAS_LOW_BASE + AOFF); // [RULE8]
      assign hit_high[g] = (i_paddr == HIGH_BASE + QOFF) || // [RULE7]
                           (i_paddr == ALIAS_HIGH_BASE + AOFF); // [RULE9]
      assign hit_ctrl[g] = (i_paddr == CTRL_BASE + QOFF);
      assign hit_head[g] = (i_paddr == HEAD_BASE + QOFF);
      assign hit_tail[g] = (i_paddr == TAIL_BASE + QOFF);

      completion_queue u_queue
      (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_wr_low(apb_wr && hit_low[g]),
        .i_wr_high(apb_wr && hit_high[g]),
        .i_wr_ctrl(apb_wr && hit_ctrl[g]),
        .i_wr_tail(apb_wr && hit_tail[g]),
        .i_wdata(i_pwdata),
        .i_desc_done(i_desc_done[g]),
        .i_throttle_expiry(i_throttle_expiry[g]),
        .i_thresh_req(i_thresh_req[g]),
        .i_wb_grant(q_grant[g]),
        .o_low(q_low[g]),
        .o_high(q_high[g]),
        .o_ctrl(q_ctrl[g]),
        .o_head(q_head[g]),
        .o_tail(q_tail[g]),
        .o_wb_pending(q_pend[g]),
        .o_flush_pulse(o_desc_flush[g]),
        .o_desc_wb_allow(o_desc_wb_allow[g])
      );
    end
  endgenerate

  // ==========================================================
  // Launch-time bias register
  logic [BIAS_W-1:0] bias_q;
  logic bias_fixed_q;

  wire hit_bias = (i_paddr == BIAS_ADDR); // [RULE10]
  wire [31:0] bias_rd = {bias_fixed_q, 1'b0, bias_q, 5'b00000}; // [RULE13]

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      bias_q <= BIAS_RESET; // [RULE10]
      bias_fixed_q <= BIAS_FIXED_RESET; // [RULE13]
    end
    else if (apb_wr && hit_bias)
    begin
      bias_q <= i_pwdata[BIAS_MSB:BIAS_LSB]; // [RULE10]
      bias_fixed_q <= i_pwdata[BIAS_FIXED_BIT]; // [RULE13]
    end
  end

  // ==========================================================
  // Read mux
  logic [31:0] q_rd_data;
  logic q_hit;

  always_comb
  begin
    q_rd_data = 32'h0000_0000;
    q_hit = 1'b0;
    for (int n = 0; n < NUM_Q; n++)
    begin
      if (hit_low[n])
        q_rd_data = q_rd_data | q_low[n];
      if (hit_high[n])
        q_rd_data = q_rd_data | q_high[n];
      if (hit_ctrl[n])
        q_rd_data = q_rd_data | q_ctrl[n];
      if (hit_head[n])
        q_rd_data = q_rd_data | {{(32-PTR_W){1'b0}}, q_head[n]};
      if (hit_tail[n])
        q_rd_data = q_rd_data | {{(32-PTR_W){1'b0}}, q_tail[n]};
      q_hit = q_hit | hit_low[n] | hit_high[n] | hit_ctrl[n] | hit_head[n] | hit_tail[n];
    end
  end

  wire head_ro = |hit_head;
  wire mapped = word_aligned && (q_hit || hit_bias);
  wire bad_access = !mapped || (i_pwrite && head_ro);
  wire [31:0] rd_data = hit_bias ? bias_rd : q_rd_data;

  // One wait state: answer on the second access-phase edge
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apb_access && !pready_q;
      pslverr_q <= apb_access && !pready_q && bad_access;
      if (apb_access && !pready_q)
        prdata_q <= (bad_access || i_pwrite) ? ERR_DATA : rd_data;
    end
  end

  // ==========================================================
  // Head write-back engine
  wb_state_e wb_state_q;
  logic [1:0] rr_q;
  logic [1:0] sel_q;
  logic wr_valid_q;
  logic [63:0] wr_addr_q;
  logic [31:0] wr_data_q;

  // Round robin from the queue after the last one served
  logic [1:0] pick;
  logic pick_ok;

  always_comb
  begin
    pick = rr_q;
    pick_ok = 1'b0;
    for (int k = NUM_Q - 1; k >= 0; k--)
    begin
      if (q_pend[2'(rr_q + 2'(k))])
      begin
        pick = 2'(rr_q + 2'(k));
        pick_ok = 1'b1;
      end
    end
  end

  wire wb_start = (wb_state_q == WB_IDLE) && pick_ok;
  wire wb_done = (wb_state_q == WB_BUSY) && i_mem_wr_ready;
  // Quadword aligned: low bits 2:0 forced to zero
  wire [63:0] pick_addr = {q_high[pick], q_low[pick][31:QWORD_LSB], 3'b000}; // [RULE4] [RULE5] [RULE17]
  wire [31:0] pick_data = {{(32-PTR_W){1'b0}}, q_head[pick]}; // [RULE17]

  // Grant clears pending at launch, so a new event during the write re-arms it
  assign q_grant = wb_start ? (NUM_Q'(1) << pick) : '0;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      wb_state_q <= WB_IDLE;
      rr_q <= 2'b00;
      sel_q <= 2'b00;
      wr_valid_q <= 1'b0;
      wr_addr_q <= 64'h0000_0000_0000_0000;
      wr_data_q <= 32'h0000_0000;
    end
    else
    begin
      case (wb_state_q)
        WB_IDLE:
        begin
          if (pick_ok)
          begin
            wb_state_q <= WB_BUSY;
            sel_q <= pick;
            rr_q <= 2'(pick + 2'b01);
            wr_valid_q <= 1'b1;
            wr_addr_q <= pick_addr; // [RULE17]
            wr_data_q <= pick_data; // [RULE17]
          end
        end
        WB_BUSY:
        begin
          if (wb_done)
          begin
            wb_state_q <= WB_IDLE;
            wr_valid_q <= 1'b0;
          end
        end
        default:
        begin
          wb_state_q <= WB_IDLE;
          wr_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_mem_wr_valid = wr_valid_q;
  assign o_mem_wr_addr = wr_addr_q;
  assign o_mem_wr_data = wr_data_q;
  assign o_mem_wr_queue = sel_q;

  // ==========================================================
  // Launch time
  logic launch_valid_q;
  logic [31:0] launch_time_q;

  // Bias is in 32 ns units; shift to ns before adding, wraps at 32 bits
  wire [31:0] bias_ns = {{(32-BIAS_W-BIAS_SHIFT){1'b0}}, bias_q, {BIAS_SHIFT{1'b0}}};

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      launch_valid_q <= 1'b0;
      launch_time_q <= 32'h0000_0000;
    end
    else
    begin
      launch_valid_q <= i_launch_req;
      if (i_launch_req)
        launch_time_q <= i_rel_launch_time + bias_ns; // [RULE11]
    end
  end

  assign o_launch_valid = launch_valid_q;
  assign o_launch_time = launch_time_q;

  // ==========================================================
  // Bus outputs
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;
endmodule

/* File: host_mem_model.sv */
// Host memory that accepts head write-backs, prompt or with stalls
`timescale 1ns/1ps
module host_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic i_valid,
  output logic o_ready
);
  logic [1:0] cnt_q = 2'h0;
  logic ready_q = 1'b0;
  assign o_ready = ready_q;
  // Slow mode takes one beat in four, so the engine must hold its request
  always @(posedge i_sys_clk)
  begin
    cnt_q <= i_valid ? cnt_q + 2'h1 : 2'h0;
    ready_q <= !i_slow || (cnt_q == 2'h2);
  end
endmodule

/* File: tx_cwb_props.sv */
// Port timing checker for the completion write-back block
`timescale 1ns/1ps
module tx_cwb_props
  import tx_cwb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_mem_wr_valid,
  input wire logic [63:0] o_mem_wr_addr,
  input wire logic [31:0] o_mem_wr_data,
  input wire logic i_mem_wr_ready,
  input wire logic [NUM_Q-1:0] o_desc_wb_allow,
  input wire logic i_launch_req,
  input wire logic o_launch_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // Register bus
  AST_WAIT_ONE: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  AST_MISALIGN_ERR: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("misaligned access not refused");
  AST_ERR_ZERO: assert property (o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("refused access returned data");
  // ==========================================================
  // Head write-back and launch
  AST_MEM_HOLD: assert property (o_mem_wr_valid && !i_mem_wr_ready |=> o_mem_wr_valid
    && $stable(o_mem_wr_addr) && $stable(o_mem_wr_data))
    else $error("write-back request changed while stalled");
  AST_QWORD: assert property (o_mem_wr_valid |-> o_mem_wr_addr[2:0] == 3'h0)
    else $error("write-back address not quadword aligned");
  AST_HEAD_WIDTH: assert property (o_mem_wr_valid |-> o_mem_wr_data[31:PTR_W] == '0)
    else $error("write-back data wider than head");
  AST_LAUNCH_NEXT: assert property (i_launch_req |=> o_launch_valid)
    else $error("launch result missing");
  AST_LAUNCH_ONLY: assert property (!i_launch_req |=> !o_launch_valid)
    else $error("launch result without request");
  AST_RESET_ALLOW: assert property ($fell(i_srst) |-> o_desc_wb_allow == 4'hF
    && !o_mem_wr_valid)
    else $error("write-back state not cleared by reset");
  cover property (o_mem_wr_valid && !i_mem_wr_ready);
  cover property (o_pslverr);
  cover property (o_launch_valid);
endmodule

bind tx_completion_writeback_launch tx_cwb_props props_u (.i_sys_clk, .i_srst, .i_psel,
  .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_mem_wr_valid, .o_mem_wr_addr,
  .o_mem_wr_data, .i_mem_wr_ready, .o_desc_wb_allow, .i_launch_req, .o_launch_valid);

/* File: tx_completion_writeback_launch_bench.sv */
// Self-checking bench for the completion write-back and launch-time block
`timescale 1ns/1ps
module tx_completion_writeback_launch_bench;
  import tx_cwb_pkg::*;
  logic i_sys_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0, qi;
  logic [31:0] i_pwdata = '0, i_rel_launch_time = '0, o_prdata, o_mem_wr_data, o_launch_time;
  logic o_pready, o_pslverr, o_mem_wr_valid, i_mem_wr_ready, o_launch_valid;
  logic i_launch_req = 1'b0, slow = 1'b0;
  logic [NUM_Q-1:0] i_desc_done = '0, i_throttle_expiry = '0, i_thresh_req = '0;
  logic [NUM_Q-1:0] o_desc_flush, o_desc_wb_allow, flush_seen = '0;
  logic [63:0] o_mem_wr_addr;
  logic [1:0] o_mem_wr_queue;
  logic [1:0] ctl_bits [NUM_Q] = '{2'h3, 2'h2, 2'h3, 2'h1};
  logic [32:0] bus_q [$];
  logic [97:0] mem_q [$];
  logic [31:0] launch_q [$];
  logic [31:0] rnd = 32'h0000_717B, bias, lows [NUM_Q], highs [NUM_Q];
  int mismatches = 0, compares = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  tx_completion_writeback_launch dut_u (.i_sys_clk, .i_srst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_desc_done, .i_throttle_expiry,
    .i_thresh_req, .o_mem_wr_valid, .o_mem_wr_addr, .o_mem_wr_data, .o_mem_wr_queue,
    .i_mem_wr_ready, .o_desc_flush, .o_desc_wb_allow, .i_launch_req, .i_rel_launch_time,
    .o_launch_valid, .o_launch_time);
  host_mem_model mem_u (.i_sys_clk, .i_slow(slow), .i_valid(o_mem_wr_valid),
    .o_ready(i_mem_wr_ready));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [97:0] exp, input logic [97:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One idle cycle after each transfer keeps drivers from double assignment
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [32:0] e);
    bus_q.push_back(e);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    // No fixed wait: only the watchdog ends a stalled transfer
    do
      @(posedge i_sys_clk);
    while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {1'b0, ERR_DATA});
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic wait_mem();
    repeat (40)
    begin
      @(posedge i_sys_clk);
      if (mem_q.size() == 0)
        break;
    end
  endtask

  task automatic complete_run();
    if (bus_q.size() + mem_q.size() + launch_q.size() != 0)
      mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Result monitor
  always @(posedge i_sys_clk)
  begin
    // Outputs are unknown before the first reset edge
    if (!i_srst)
      flush_seen <= flush_seen | o_desc_flush;
    if (!i_srst && o_pready === 1'b1)
      chk("apb", bus_q.size() ? {65'h0, bus_q.pop_front()} : '1, {65'h0, o_pslverr, o_prdata});
    if (o_mem_wr_valid === 1'b1 && i_mem_wr_ready === 1'b1)
      chk("mem", mem_q.size() ? mem_q.pop_front() : '1,
        {o_mem_wr_queue, o_mem_wr_addr, o_mem_wr_data});
    if (o_launch_valid === 1'b1)
      chk("launch", launch_q.size() ? {66'h0, launch_q.pop_front()} : '1,
        {66'h0, o_launch_time});
  end

  initial
  begin
    #100us;
    mismatches++;
    complete_run();
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    rd(LOW_BASE, LOW_RESET);
    rd(HIGH_BASE + Q_STRIDE, HIGH_RESET);
    rd(BIAS_ADDR, 32'h8000_0000);
    $display("reset test done");
    // Bias kept small so launch times stay below one second
    bias = (next_rnd(rnd) & 32'h1FFF_FFFF) | 32'h8000_0000;
    wr(BIAS_ADDR, bias);
    rd(BIAS_ADDR, bias & 32'hBFFF_FFE0);
    rnd = next_rnd(bias);
    launch_q.push_back((rnd & 32'h00FF_FFFF) + (bias & 32'h3FFF_FFE0));
    i_rel_launch_time <= rnd & 32'h00FF_FFFF;
    i_launch_req <= 1'b1;
    @(posedge i_sys_clk);
    i_launch_req <= 1'b0;
    @(posedge i_sys_clk);
    $display("launch test done");
    for (int q = 0; q < NUM_Q; q++)
    begin
      qi = 16'(q);
      rnd = next_rnd(rnd);
      lows[q] = {rnd[31:2], ctl_bits[q]};
      highs[q] = next_rnd(rnd);
      rnd = highs[q];
      wr(q[0] ? ALIAS_LOW_BASE + ALIAS_STRIDE * qi : LOW_BASE + Q_STRIDE * qi, lows[q]);
      rd(q[0] ? LOW_BASE + Q_STRIDE * qi : ALIAS_LOW_BASE + ALIAS_STRIDE * qi, lows[q]);
      wr(q[0] ? HIGH_BASE + Q_STRIDE * qi : ALIAS_HIGH_BASE + ALIAS_STRIDE * qi, highs[q]);
      rd(q[0] ? ALIAS_HIGH_BASE + ALIAS_STRIDE * qi : HIGH_BASE + Q_STRIDE * qi, highs[q]);
    end
    chk("allow", 98'h2, {94'h0, o_desc_wb_allow});
    apb(1'b0, 16'h1000, 32'h0, {1'b1, ERR_DATA});
    apb(1'b1, LOW_BASE + 16'h0002, 32'hFFFF_FFFF, {1'b1, ERR_DATA});
    rd(LOW_BASE, lows[0]);
    $display("register test done");
    wr(CTRL_BASE, 32'h0200_0000);
    wr(TAIL_BASE, 32'h0000_0003);
    repeat (5)
    begin
      i_desc_done <= 4'h1;
      @(posedge i_sys_clk);
      i_desc_done <= 4'h0;
      @(posedge i_sys_clk);
    end
    rd(HEAD_BASE, 32'h0000_0003);
    slow <= 1'b1;
    for (int q = 0; q < NUM_Q; q++)
    begin
      if (ctl_bits[q] == 2'h3)
        mem_q.push_back({2'(q), highs[q], lows[q][31:3], 3'h0, q == 0 ? 32'h3 : 32'h0});
      i_throttle_expiry <= 4'h1 << q;
      @(posedge i_sys_clk);
      i_throttle_expiry <= 4'h0;
      wait_mem();
    end
    // Queue 1 has write-back off; the rest are served round robin from queue 3
    mem_q.push_back({2'h3, highs[3], lows[3][31:3], 3'h0, 32'h0});
    mem_q.push_back({2'h0, highs[0], lows[0][31:3], 3'h0, 32'h3});
    mem_q.push_back({2'h2, highs[2], lows[2][31:3], 3'h0, 32'h0});
    i_thresh_req <= 4'hF;
    @(posedge i_sys_clk);
    i_thresh_req <= 4'h0;
    wait_mem();
    $display("write-back test done");
    wr(CTRL_BASE, 32'h0600_0000);
    wr(CTRL_BASE + Q_STRIDE, 32'h0400_0000);
    @(posedge i_sys_clk);
    chk("flush", 98'h2, {94'h0, flush_seen});
    wr(CTRL_BASE, 32'h0000_0000);
    wr(CTRL_BASE, 32'h0200_0000);
    rd(HEAD_BASE, 32'h0000_0000);
    rd(TAIL_BASE, 32'h0000_0000);
    $display("flush and enable test done");
    repeat (4) @(posedge i_sys_clk);
    complete_run();
  end
endmodule
